// ===== nvsram_host.sv
// Host controller driving an asynchronous nonvolatile static memory by its pins.
// Assumes one command at a time on REQ/CMD and a pull-up on the save/busy pin.
//
// Summary of operation
// - Write strobe stays high during every read
// - Save/busy pin left high during accesses
// - Select held to write end per grade
// - Byte lanes held to write end per grade
`timescale 1ns/10ps
module nvsram_host
   import nvsram_host_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic NRST,
   input wire logic CLK_EN,
   input wire logic [1:0] ORG,
   input wire logic [1:0] GRADE,
   input wire logic REQ,
   input wire cmd_t CMD,
   output logic BUSY,
   output logic DONE,
   output logic [DATA_W-1:0] RDATA,
   output logic CHIP_SELECT_FIRST_N,
   output logic CHIP_SELECT_SECOND,
   output logic WE_N,
   output logic OE_N,
   output logic LOW_BYTE_LANE_N,
   output logic HIGH_BYTE_LANE_N,
   output logic [LANES-1:0] LANE_N,
   output logic [ADDR_W-1:0] ADDR,
   output logic [DATA_W-1:0] DQ_O,
   output logic DQ_OE,
   input wire logic [DATA_W-1:0] DQ_I,
   input wire logic HW_SAVE_BUSY_N_I,
   output logic HW_SAVE_BUSY_N_O,
   output logic HW_SAVE_BUSY_N_OE
);
   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_READ, ST_WRITE, ST_RELEASE, ST_RECOVER}
      state_t;

   state_t state_q, state_d;
   cmd_t cmd_q, cmd_d;
   pins_t pins_q, pins_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic done_q, done_d;
   logic busy_q, busy_d;
   logic [DATA_W:0] sync_out;

   pin_sync #(.W(DATA_W + 1)) u_sync (
      .clk(REF_CLK),
      .rst_n(NRST),
      .ce(CLK_EN),
      .d({HW_SAVE_BUSY_N_I, DQ_I}),
      .q(sync_out)
   );

   wire [DATA_W-1:0] dq_sync = sync_out[DATA_W-1:0];
   // A low save/busy pin means a save, restore or brown-out; accesses would be ignored
   wire device_busy = ~sync_out[DATA_W];
   wire cnt_zero = (cnt_q == '0);

   // Waits per grade; reads add the synchroniser depth before the data is trusted
   wire [CNT_W-1:0] read_cnt = CNT_W'(ACE_CYC[GRADE] + SYNC_STAGES - 1);
   wire [CNT_W-1:0] write_cnt = CNT_W'(PWE_CYC[GRADE] - 1);
   wire [CNT_W-1:0] hz_cnt = CNT_W'(HZ_CYC[GRADE] - 1);

   // Lane pins follow the organisation; unused lanes stay inactive
   wire use16 = (ORG == ORG_X16);
   wire use32 = (ORG == ORG_X32);
   wire low_n_sel = ~(use16 & cmd_q.lanes[0]);
   wire high_n_sel = ~(use16 & cmd_q.lanes[1]);
   wire [LANES-1:0] lane_n_sel = ~({LANES{use32}} & cmd_q.lanes);

   always_comb begin
      state_d = state_q;
      cmd_d = cmd_q;
      pins_d = pins_q;
      cnt_d = cnt_q;
      rdata_d = rdata_q;
      done_d = 1'b0;
      busy_d = 1'b1;
      case (state_q)
         ST_IDLE: begin
            busy_d = 1'b0;
            pins_d = PINS_IDLE;
            if (REQ && !device_busy) begin
               cmd_d = CMD;
               // Address and data lead the strobes by a cycle, so no select opens on a moving bus
               pins_d.addr = CMD.addr;
               pins_d.dq = CMD.wdata;
               busy_d = 1'b1;
               state_d = ST_SETUP;
            end
         end
         ST_SETUP: begin
            // Address settles with every strobe inactive
            pins_d.addr = cmd_q.addr;
            pins_d.dq = cmd_q.wdata;
            // Both selects driven together so the internal select is clean
            pins_d.cs1_n = 1'b0;
            pins_d.cs2 = 1'b1;
            pins_d.low_n = low_n_sel;
            pins_d.high_n = high_n_sel;
            pins_d.lane_n = lane_n_sel;
            if (cmd_q.write) begin
               // Write strobe falls with the select so the device never drives
               pins_d.we_n = 1'b0;
               pins_d.oe_n = 1'b1;
               pins_d.dq_oe = 1'b1;
               cnt_d = write_cnt;
               state_d = ST_WRITE;
            end else begin
               pins_d.we_n = 1'b1;
               pins_d.oe_n = 1'b0;
               pins_d.dq_oe = 1'b0;
               cnt_d = read_cnt;
               state_d = ST_READ;
            end
         end
         ST_READ: begin
            cnt_d = cnt_q - 1'b1;
            if (cnt_zero) begin
               rdata_d = dq_sync;
               done_d = 1'b1;
               pins_d.cs1_n = 1'b1;
               pins_d.cs2 = 1'b0;
               pins_d.oe_n = 1'b1;
               pins_d.low_n = 1'b1;
               pins_d.high_n = 1'b1;
               pins_d.lane_n = 4'hF;
               cnt_d = hz_cnt;
               state_d = ST_RECOVER;
            end
         end
         ST_WRITE: begin
            cnt_d = cnt_q - 1'b1;
            if (cnt_zero) begin
               // Select, lanes and strobe end together after the full pulse
               pins_d.we_n = 1'b1;
               pins_d.cs1_n = 1'b1;
               pins_d.cs2 = 1'b0;
               pins_d.low_n = 1'b1;
               pins_d.high_n = 1'b1;
               pins_d.lane_n = 4'hF;
               state_d = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            // Data held one cycle past the write end, then floated
            pins_d.dq_oe = 1'b0;
            cnt_d = hz_cnt;
            state_d = ST_RECOVER;
         end
         ST_RECOVER: begin
            // Bus turnaround: nobody drives data until the device has let go
            cnt_d = cnt_q - 1'b1;
            if (cnt_zero) begin
               busy_d = 1'b0;
               state_d = ST_IDLE;
            end
         end
         default: begin
            pins_d = PINS_IDLE;
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         state_q <= ST_IDLE;
         cmd_q <= '0;
         cnt_q <= '0;
      end else if (CLK_EN) begin
         state_q <= state_d;
         cmd_q <= cmd_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         pins_q <= PINS_IDLE;
         rdata_q <= '0;
         done_q <= 1'b0;
         busy_q <= 1'b0;
      end else if (CLK_EN) begin
         pins_q <= pins_d;
         rdata_q <= rdata_d;
         done_q <= done_d;
         busy_q <= busy_d;
      end
   end

   assign BUSY = busy_q;
   assign DONE = done_q;
   assign RDATA = rdata_q;
   assign CHIP_SELECT_FIRST_N = pins_q.cs1_n;
   assign CHIP_SELECT_SECOND = pins_q.cs2;
   assign WE_N = pins_q.we_n;
   assign OE_N = pins_q.oe_n;
   assign LOW_BYTE_LANE_N = pins_q.low_n;
   assign HIGH_BYTE_LANE_N = pins_q.high_n;
   assign LANE_N = pins_q.lane_n;
   assign ADDR = pins_q.addr;
   assign DQ_O = pins_q.dq;
   assign DQ_OE = pins_q.dq_oe;
   // The save/busy pin is never driven; the pull-up keeps it high for accesses
   assign HW_SAVE_BUSY_N_O = 1'b1;
   assign HW_SAVE_BUSY_N_OE = 1'b0;
endmodule

// ===== nvsram_host_pkg.sv
// Shared types and timing constants for the static memory host port.
// Assumes a 50 MHz REF_CLK; all device delays are turned into whole cycles here.
package nvsram_host_pkg;

   localparam int CLK_PERIOD_NS = 20;
   localparam int SYNC_STAGES = 2;
   localparam int ADDR_W = 21;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int CNT_W = 4;

   // Organisation select
   localparam logic [1:0] ORG_X8 = 2'h0;
   localparam logic [1:0] ORG_X16 = 2'h1;
   localparam logic [1:0] ORG_X32 = 2'h2;

   // Device limits per speed grade, in ns
   localparam int T_ACE_NS [4] = '{25, 30, 35, 45};
   localparam int T_DOE_NS [4] = '{12, 14, 15, 20};
   localparam int T_HZ_NS [4] = '{10, 12, 13, 15};
   localparam int T_PWE_NS [4] = '{20, 24, 25, 30};
   localparam int T_LZWE_NS = 3;

   function automatic int ceil_cyc(input int ns);
      return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction

   function automatic int max2(input int a, input int b);
      return (a > b) ? a : b;
   endfunction

   localparam int ACE_CYC [4] = '{ceil_cyc(max2(T_ACE_NS[0], T_DOE_NS[0])),
      ceil_cyc(max2(T_ACE_NS[1], T_DOE_NS[1])), ceil_cyc(max2(T_ACE_NS[2], T_DOE_NS[2])),
      ceil_cyc(max2(T_ACE_NS[3], T_DOE_NS[3]))};
   localparam int HZ_CYC [4] = '{ceil_cyc(max2(T_HZ_NS[0], T_LZWE_NS)),
      ceil_cyc(max2(T_HZ_NS[1], T_LZWE_NS)), ceil_cyc(max2(T_HZ_NS[2], T_LZWE_NS)),
      ceil_cyc(max2(T_HZ_NS[3], T_LZWE_NS))};
   localparam int PWE_CYC [4] = '{ceil_cyc(T_PWE_NS[0]), ceil_cyc(T_PWE_NS[1]),
      ceil_cyc(T_PWE_NS[2]), ceil_cyc(T_PWE_NS[3])};

   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [LANES-1:0] lanes;
   } cmd_t;

   typedef struct packed {
      logic cs1_n;
      logic cs2;
      logic we_n;
      logic oe_n;
      logic low_n;
      logic high_n;
      logic [LANES-1:0] lane_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq;
      logic dq_oe;
   } pins_t;

   localparam pins_t PINS_IDLE = '{cs1_n: 1'b1, cs2: 1'b0, we_n: 1'b1, oe_n: 1'b1,
      low_n: 1'b1, high_n: 1'b1, lane_n: 4'hF, addr: 21'h000000, dq: 32'h00000000,
      dq_oe: 1'b0};

endpackage

// ===== nvsram_host_props.sv
// Checker for the static memory host port, bound to every nvsram_host.
// Assumes CLK_EN stays high while an access runs.
`timescale 1ns/10ps
module nvsram_host_props
   import nvsram_host_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic NRST,
   input wire logic [1:0] ORG,
   input wire logic [1:0] GRADE,
   input wire logic DONE,
   input wire logic CHIP_SELECT_FIRST_N,
   input wire logic CHIP_SELECT_SECOND,
   input wire logic WE_N,
   input wire logic OE_N,
   input wire logic LOW_BYTE_LANE_N,
   input wire logic HIGH_BYTE_LANE_N,
   input wire logic [LANES-1:0] LANE_N,
   input wire logic HW_SAVE_BUSY_N_OE
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   property p_rd_we; !OE_N |-> WE_N; endproperty
   a_rd_we: assert property (p_rd_we) else $error("write strobe low in read");
   property p_hsb; !HW_SAVE_BUSY_N_OE; endproperty
   a_hsb: assert property (p_hsb) else $error("save pin driven");
   property p_sel; CHIP_SELECT_FIRST_N == !CHIP_SELECT_SECOND; endproperty
   a_sel: assert property (p_sel) else $error("selects disagree");
   property p_x16; ORG != ORG_X16 |-> LOW_BYTE_LANE_N && HIGH_BYTE_LANE_N; endproperty
   a_x16: assert property (p_x16) else $error("byte lanes outside x16");
   property p_x32; ORG != ORG_X32 |-> LANE_N == 4'hF; endproperty
   a_x32: assert property (p_x32) else $error("lanes outside x32");
   property p_wlen; $fell(WE_N) && GRADE != 2'h0 |-> !WE_N ##1 !WE_N ##1 WE_N; endproperty
   a_wlen: assert property (p_wlen) else $error("write pulse length");
   property p_wlen0; $fell(WE_N) && GRADE == 2'h0 |-> !WE_N ##1 WE_N; endproperty
   a_wlen0: assert property (p_wlen0) else $error("short write pulse length");
   property p_whold; !WE_N && !$past(WE_N) |-> $stable(LANE_N) && !CHIP_SELECT_FIRST_N; endproperty
   a_whold: assert property (p_whold) else $error("lanes or select moved");
   property p_rlat; $fell(OE_N) && GRADE != 2'h3 |-> ##4 DONE; endproperty
   a_rlat: assert property (p_rlat) else $error("read capture late");
   property p_rlat3; $fell(OE_N) && GRADE == 2'h3 |-> ##5 DONE; endproperty
   a_rlat3: assert property (p_rlat3) else $error("slow read capture late");
   property p_off; DONE |-> OE_N && CHIP_SELECT_FIRST_N; endproperty
   a_off: assert property (p_off) else $error("strobes on at capture");
endmodule

bind nvsram_host nvsram_host_props u_props (.REF_CLK(REF_CLK), .NRST(NRST), .ORG(ORG),
   .GRADE(GRADE), .DONE(DONE), .CHIP_SELECT_FIRST_N(CHIP_SELECT_FIRST_N),
   .CHIP_SELECT_SECOND(CHIP_SELECT_SECOND), .WE_N(WE_N), .OE_N(OE_N),
   .LOW_BYTE_LANE_N(LOW_BYTE_LANE_N), .HIGH_BYTE_LANE_N(HIGH_BYTE_LANE_N),
   .LANE_N(LANE_N), .HW_SAVE_BUSY_N_OE(HW_SAVE_BUSY_N_OE));

// ===== nvsram_model.sv
// Behavioural model of the static memory on the host port's pins.
// Assumes the bench resolves the shared data and save/busy wires.
`timescale 1ns/10ps
module nvsram_model
   import nvsram_host_pkg::*;
(
   input wire logic cs1_n,
   input wire logic cs2,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic low_n,
   input wire logic high_n,
   input wire logic [LANES-1:0] lane_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] dq_in,
   input wire logic [1:0] org,
   input wire logic [1:0] grade,
   input wire logic slow,
   input wire logic save_busy,
   output logic [DATA_W-1:0] dq_out,
   output logic save_busy_n
);
   // Only the low six address bits are kept; scenarios stay inside 64 words
   logic [DATA_W-1:0] mem [64] = '{default: 32'h00000000};
   logic [DATA_W-1:0] mask, word, old, rd_word;
   wire sel = !cs1_n && cs2;
   wire rd_en = sel && we_n && !oe_n && !save_busy;
   wire wr_en = sel && !we_n && !save_busy;
   initial dq_out = 32'h5A5A5A5A;
   assign save_busy_n = !save_busy;
   always @* begin
      mask = 32'h000000FF;
      if (org == ORG_X16) mask = {16'h0000, {8{!high_n}}, {8{!low_n}}};
      if (org == ORG_X32) mask = {{8{!lane_n[3]}}, {8{!lane_n[2]}}, {8{!lane_n[1]}}, {8{!lane_n[0]}}};
   end
   // Level-sensitive write: reapplying the same data is harmless, so no edge race
   always @(wr_en, addr, dq_in, mask) begin
      old = mem[addr[5:0]];
      word = (old & ~mask) | (dq_in & mask);
      if (wr_en) mem[addr[5:0]] = word;
   end
   always @(rd_en, addr, mask) begin
      rd_word = mem[addr[5:0]] & mask;
      if (rd_en) dq_out <= #(slow ? T_ACE_NS[grade] : 4) rd_word;
      else dq_out <= #(T_HZ_NS[grade]) ~dq_out;
   end
endmodule

// ===== pin_sync.sv
// Two-stage synchroniser for a bus of pin inputs.
// Assumes each bit is sampled independently; words are only read once stable.
`timescale 1ns/10ps
module pin_sync
   import nvsram_host_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            meta_q[i] <= 1'b0;
            q[i] <= 1'b0;
         end else if (ce) begin
            meta_q[i] <= d[i];
            q[i] <= meta_q[i];
         end
      end
   end
endmodule

// ===== testbench.sv
// Self-checking bench: nvsram_host driving the device model.
// Assumes the model drives the save/busy wire and the data wire resolved here.
`timescale 1ns/10ps
module testbench;
   import nvsram_host_pkg::*;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic req = 1'b0;
   logic slow = 1'b0;
   logic save_busy = 1'b0;
   logic [1:0] org = 2'h0;
   logic [1:0] grade = 2'h0;
   cmd_t cmd = '0;
   logic busy, done, cs1_n, cs2, we_n, oe_n, low_n, high_n, dq_oe, hsb_o, hsb_oe, dev_hsb_n;
   logic [LANES-1:0] lane_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] rdata, dq_o, dq_dev;
   int fails = 0;
   int samples_checked = 0;
   wire [DATA_W-1:0] dq_i = dq_oe ? dq_o : dq_dev;
   wire hsb_i = hsb_oe ? hsb_o : dev_hsb_n;

   nvsram_host u_dut (.REF_CLK(ref_clk), .NRST(nrst), .CLK_EN(1'b1), .ORG(org), .GRADE(grade),
      .REQ(req), .CMD(cmd), .BUSY(busy), .DONE(done), .RDATA(rdata),
      .CHIP_SELECT_FIRST_N(cs1_n), .CHIP_SELECT_SECOND(cs2), .WE_N(we_n), .OE_N(oe_n),
      .LOW_BYTE_LANE_N(low_n), .HIGH_BYTE_LANE_N(high_n), .LANE_N(lane_n), .ADDR(addr),
      .DQ_O(dq_o), .DQ_OE(dq_oe), .DQ_I(dq_i), .HW_SAVE_BUSY_N_I(hsb_i),
      .HW_SAVE_BUSY_N_O(hsb_o), .HW_SAVE_BUSY_N_OE(hsb_oe));
   nvsram_model u_mem (.cs1_n(cs1_n), .cs2(cs2), .we_n(we_n), .oe_n(oe_n), .low_n(low_n),
      .high_n(high_n), .lane_n(lane_n), .addr(addr), .dq_in(dq_i), .org(org), .grade(grade),
      .slow(slow), .save_busy(save_busy), .dq_out(dq_dev), .save_busy_n(dev_hsb_n));

   initial forever #10 ref_clk = ~ref_clk;

   task automatic check(input string what, input logic [DATA_W-1:0] exp, got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Holds REQ until accepted; lat counts to DONE, len to BUSY low
   task automatic do_op(input logic wr, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d, input logic [3:0] ln, output int lat, output int len);
      cmd = '{write: wr, addr: a, wdata: d, lanes: ln};
      req = 1'b1;
      len = 0;
      lat = 0;
      while (busy !== 1'b1 && len < 50) begin
         @(posedge ref_clk);
         #1;
         len++;
      end
      req = 1'b0;
      len = 0;
      while (busy !== 1'b0 && len < 50) begin
         @(posedge ref_clk);
         #1;
         len++;
         if (done === 1'b1) lat = len;
         if (cs1_n === 1'b0) check("address", {11'h000, a}, {11'h000, addr});
      end
   endtask

   task automatic t_reset();
      check("idle pins", 32'h00000BFC, {cs1_n, cs2, we_n, oe_n, low_n, high_n, lane_n,
         dq_oe, hsb_oe});
      check("idle addr", 32'h00000000, {11'h000, addr});
      check("idle read data", 32'h00000000, rdata);
      check("idle status", 32'h00000001, {29'h0, busy, done, hsb_o});
      $display("reset test done");
   endtask

   task automatic t_orgs_grades();
      logic [DATA_W-1:0] d, m;
      logic [3:0] ln;
      int lat, len;
      for (int o = 0; o < 4; o++) begin
         for (int g = 0; g < 4; g++) begin
            org = o[1:0];
            grade = g[1:0];
            slow = g[0];
            ln = 4'hF ^ (4'h1 << g);
            d = 32'hC3A55A3C ^ (o * 16 + g);
            m = 32'h000000FF;
            if (o == 1) m = {16'h0000, {8{ln[1]}}, {8{ln[0]}}};
            if (o == 2) m = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
            do_op(1'b1, 21'(o * 16 + g), d, ln, lat, len);
            check("write length", PWE_CYC[g] + HZ_CYC[g] + 2, len);
            do_op(1'b0, 21'(o * 16 + g), 32'h0, ln, lat, len);
            check("read latency", ACE_CYC[g] + 3, lat);
            check("read data", d & m, rdata);
         end
      end
      $display("organisation and grade test done");
   endtask

   task automatic t_refuse();
      int lat, len;
      org = 2'h2;
      save_busy = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      req = 1'b1;
      repeat (6) @(posedge ref_clk);
      #1;
      check("busy while saving", 32'h0, {31'h0, busy});
      save_busy = 1'b0;
      do_op(1'b0, 21'h000023, 32'h0, 4'hF, lat, len);
      check("read after save", 32'h00A55A1F, rdata);
      $display("refusal test done");
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      #100000;
      fails++;
      stop_test();
   end

   initial begin
      repeat (5) @(posedge ref_clk);
      t_reset();
      repeat (5) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      t_orgs_grades();
      t_refuse();
      stop_test();
   end
endmodule
